// ---- design/vmag_addr_gen.sv ----
// Purpose: Page and character memory address generator with CPU access.
// Assumes: CPU and companion-chip pins are asynchronous to aclk.
// Notes: Pin paths add two cycles of latency through synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "vmag_defines.svh"
module vmag_addr_gen
(
   input wire logic aclk, // System clock, 125 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [7:0] cpu_mux_addr_in, // Multiplexed CPU address
   input wire logic [2:0] cpu_io_sel, // I/O port number, 0 idle
   input wire logic cpu_tpa, // High-byte address strobe
   input wire logic cpu_tpb, // I/O latch strobe, falling edge
   input wire logic cpu_mrd_n, // Memory read, active low
   input wire logic cpu_mwr_n, // Memory write, active low
   input wire logic display_n, // Low during display field
   input wire logic addr_strobe, // Character advance in display
   input wire logic [7:0] page_mem_data_in, // Page memory data
   input wire logic [7:0] cpu_data_lines_in, // CPU data pins in
   output logic [7:0] cpu_data_lines_out, // CPU data pins out
   output logic cpu_data_lines_oe, // CPU data drive enable
   input wire logic [7:0] char_data_in, // Character data pins in
   output logic [7:0] char_data_out, // Character data pins out
   output logic char_data_oe, // Character data drive enable
   output logic [10:0] page_mem_addr_out, // Page memory address
   output logic [3:0] char_row_addr_out, // Character row address
   output logic [7:0] char_col_addr_out, // Character column address
   output logic page_mem_select, // Page memory selected
   output logic char_mem_select, // Character memory selected
   output logic char_mem_write_strobe, // Character memory write
   output logic [14:0] bitmap_addr_out // Bit-map memory address
);
   import vmag_pkg::*;

   vmag_state_t s;
   vmag_state_t n;
   logic [10:0] rfsh_cnt;
   logic frame_end;
   logic adv;
   logic [15:0] full_addr;
   logic tpb_fall;
   logic disp_act;
   logic mem_rd;
   logic mem_wr;
   logic mem_cyc;
   logic page_hit;
   logic char_hit;
   logic [33:0] rd_word;

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Merge write data into a register by byte lanes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Read decode: response in bits 33:32, data below
   function automatic logic [33:0] read_reg(input logic [7:0] a,
                                            input vmag_state_t st,
                                            input logic [10:0] rc);
      logic [33:0] r;
      r = {`VMAG_RESP_OKAY, 32'h0000_0000};
      unique case (a)
         `VMAG_CTRL_OFF: r[2:0] = {st.bmap, st.tall, st.dbl};
         `VMAG_LAST_OFF: r[10:0] = st.last;
         `VMAG_STAT_OFF: r[2:0] = {!st.p2.disp_n, st.addressed, st.access};
         `VMAG_PADR_OFF: r[10:0] = st.pma;
         `VMAG_HOME_OFF: r[10:0] = st.home;
         `VMAG_RFSH_OFF: r[10:0] = rc;
         default: r = {`VMAG_RESP_SLVERR, 32'h0000_0000};
      endcase
      return r;
   endfunction

   // ****************************************************************
   // Refresh counter
   // ****************************************************************

   // Counter lives apart so reload and roll stay easy to read
   vmag_refresh_ctr u_rfsh
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .adv(adv),
      .frame_end(frame_end),
      .home(s.home),
      .last(s.last),
      .cnt(rfsh_cnt)
   );

   // Event decode from the second synchroniser stage only
   always_comb
   begin
      full_addr = {s.addr_hi, s.p2.addr};
      tpb_fall = s.tpb_d && !s.p2.tpb;
      disp_act = !s.p2.disp_n;
      frame_end = s.p2.disp_n && !s.disp_d;
      adv = disp_act && s.p2.addstb && !s.stb_d;
      mem_rd = !s.p2.mrd_n;
      mem_wr = !s.p2.mwr_n && s.p2.mrd_n;
      mem_cyc = s.access && !disp_act && (mem_rd || mem_wr);
      page_hit = full_addr[15:11] == `VMAG_PAGE_HI;
      char_hit = full_addr[15:10] == `VMAG_CHAR_HI;
      rd_word = read_reg(s_axi_araddr, s, rfsh_cnt);
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************

   // Pins, CPU ports, memory cycles, register bus
   always_comb
   begin
      n = s;
      n.p1 = {cpu_mux_addr_in, cpu_data_lines_in, char_data_in,
              page_mem_data_in, cpu_io_sel, cpu_tpa, cpu_tpb,
              cpu_mrd_n, cpu_mwr_n, display_n, addr_strobe};
      n.p2 = s.p1;
      n.tpa_d = s.p2.tpa;
      n.tpb_d = s.p2.tpb;
      n.disp_d = s.p2.disp_n;
      n.stb_d = s.p2.addstb;

      // High address byte arrives first on the shared pins
      if (s.p2.tpa && !s.tpa_d)
      begin
         n.addr_hi = s.p2.addr;
      end

      // Output-port instructions
      if (tpb_fall)
      begin
         unique case (s.p2.nsel)
            `VMAG_PORT_MODE:
            begin
               n.access = s.p2.data[`VMAG_ACC_BIT];
               n.addressed = 1'b0;
               if (s.p2.data[`VMAG_ACC_BIT])
               begin
                  n.pma = full_addr[10:0];
               end
            end
            `VMAG_PORT_PADR:
            begin
               // Ignored while the access bit is low
               if (s.access)
               begin
                  n.pma = full_addr[10:0];
                  n.addressed = 1'b1;
               end
            end
            `VMAG_PORT_HOME:
            begin
               n.home = {full_addr[10:2], 2'b00};
            end
            default:
            begin
               n.home = s.home;
            end
         endcase
      end

      // Page address: latched value only outside display
      if (s.access && !disp_act)
      begin
         n.pma_out = s.pma;
         if (!s.dbl)
         begin
            n.pma_out[10] = 1'b0;
         end
         // Low bits pick the row; bit 3 only when tall and not dbl
         n.row_out = full_addr[3:0];
         if (!s.tall || s.dbl)
         begin
            n.row_out[3] = 1'b0;
         end
      end
      else
      begin
         n.pma_out = rfsh_cnt;
         n.row_out = 4'h0;
      end
      n.col_out = s.p2.pmd;

      // Chip selects, only when the CPU may touch memory
      n.pg_sel = mem_cyc && page_hit;
      n.cm_sel = mem_cyc && char_hit;
      n.cm_wr = mem_cyc && char_hit && mem_wr;

      // Character data path follows the select
      n.cd_oe = mem_cyc && char_hit && mem_wr;
      n.cd_out = s.p2.data;
      n.cpu_doe = mem_cyc && char_hit && mem_rd;
      n.cpu_dout = s.p2.cdata;

      // Page and row join into one bit-map address
      n.bm_addr = s.bmap ? {n.pma_out, n.row_out} : 15'h0000;

      // Register bus: write address and data in either order
      if (s_axi_awvalid && s.awready)
      begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s.wready)
      begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s.bvalid && s_axi_bready)
      begin
         n.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got && !s.bvalid)
      begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `VMAG_RESP_OKAY;
         unique case (s.awaddr)
            `VMAG_CTRL_OFF:
            begin
               {n.bmap, n.tall, n.dbl} =
                  3'(merge({29'h0, s.bmap, s.tall, s.dbl},
                           s.wdata, s.wstrb));
            end
            `VMAG_LAST_OFF:
            begin
               n.last = 11'(merge({21'h0, s.last}, s.wdata, s.wstrb));
            end
            `VMAG_STAT_OFF, `VMAG_PADR_OFF,
            `VMAG_HOME_OFF, `VMAG_RFSH_OFF:
            begin
               n.bresp = `VMAG_RESP_OKAY; // Read-only, write ignored
            end
            default:
            begin
               n.bresp = `VMAG_RESP_SLVERR;
            end
         endcase
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      // Register bus: read, one outstanding
      if (s.rvalid && s_axi_rready)
      begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s.arready)
      begin
         n.rvalid = 1'b1;
         n.rresp = rd_word[33:32];
         n.rdata = rd_word[31:0];
      end
      n.arready = !n.rvalid;
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Display syncs reset to idle high, so no false frame end follows
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.last <= `VMAG_LAST_RST;
         s.p1.disp_n <= 1'b1;
         s.p2.disp_n <= 1'b1;
         s.disp_d <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // Outputs straight from the state register
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign cpu_data_lines_out = s.cpu_dout;
   assign cpu_data_lines_oe = s.cpu_doe;
   assign char_data_out = s.cd_out;
   assign char_data_oe = s.cd_oe;
   assign page_mem_addr_out = s.pma_out;
   assign char_row_addr_out = s.row_out;
   assign char_col_addr_out = s.col_out;
   assign page_mem_select = s.pg_sel;
   assign char_mem_select = s.cm_sel;
   assign char_mem_write_strobe = s.cm_wr;
   assign bitmap_addr_out = s.bm_addr;
endmodule
`default_nettype wire

// ---- design/vmag_defines.svh ----
// Purpose: Constants for the video memory address generator.
// Assumes: Register map reached over AXI4-Lite, byte addresses.
// Notes: Operation
`ifndef VMAG_DEFINES_SVH
`define VMAG_DEFINES_SVH

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define VMAG_CTRL_OFF 8'h00
`define VMAG_LAST_OFF 8'h04
`define VMAG_STAT_OFF 8'h08
`define VMAG_PADR_OFF 8'h0C
`define VMAG_HOME_OFF 8'h10
`define VMAG_RFSH_OFF 8'h14
`define VMAG_CTRL_DBL_BIT 0
`define VMAG_CTRL_TALL_BIT 1
`define VMAG_CTRL_BMAP_BIT 2
`define VMAG_LAST_RST 11'h3BF
`define VMAG_RESP_OKAY 2'h0
`define VMAG_RESP_SLVERR 2'h2

// ****************************************************************
// CPU side decode
// ****************************************************************
`define VMAG_PORT_MODE 3'h5
`define VMAG_PORT_PADR 3'h6
`define VMAG_PORT_HOME 3'h7
`define VMAG_ACC_BIT 0
`define VMAG_PAGE_HI 5'h1F
`define VMAG_CHAR_HI 6'h3D

`endif

// ---- design/vmag_pkg.sv ----
// Purpose: Types for the video memory address generator.
// Assumes: vmag_defines.svh on the include path.
// Notes: State of each module is one packed struct.
`default_nettype none
package vmag_pkg;
   // Pin samples, used for both synchroniser stages
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] cdata;
      logic [7:0] pmd;
      logic [2:0] nsel;
      logic tpa;
      logic tpb;
      logic mrd_n;
      logic mwr_n;
      logic disp_n;
      logic addstb;
   } vmag_pins_t;

   typedef struct packed {
      vmag_pins_t p1;
      vmag_pins_t p2;
      logic tpa_d;
      logic tpb_d;
      logic disp_d;
      logic stb_d;
      logic [7:0] addr_hi;
      logic access;
      logic addressed;
      logic [10:0] pma;
      logic [10:0] home;
      logic dbl;
      logic tall;
      logic bmap;
      logic [10:0] last;
      logic awready;
      logic wready;
      logic arready;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [10:0] pma_out;
      logic [3:0] row_out;
      logic [7:0] col_out;
      logic pg_sel;
      logic cm_sel;
      logic cm_wr;
      logic [14:0] bm_addr;
      logic [7:0] cpu_dout;
      logic cpu_doe;
      logic [7:0] cd_out;
      logic cd_oe;
   } vmag_state_t;

   typedef struct packed {
      logic [10:0] cnt;
   } vmag_rfsh_t;
endpackage
`default_nettype wire

// ---- design/vmag_refresh_ctr.sv ----
// Purpose: Refresh-address counter with home reload and roll.
// Assumes: Strobes are one-cycle pulses on aclk.
// Notes: Frame end wins over an advance in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module vmag_refresh_ctr
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic adv, // Advance one character
   input wire logic frame_end, // Display frame finished
   input wire logic [10:0] home, // Home address
   input wire logic [10:0] last, // Final page-memory count
   output logic [10:0] cnt // Refresh address
);
   import vmag_pkg::*;

   vmag_rfsh_t s;
   vmag_rfsh_t n;

   // Next count
   always_comb
   begin
      n = s;
      if (frame_end)
      begin
         n.cnt = home;
      end
      else if (adv)
      begin
         if (s.cnt == last)
         begin
            n.cnt = 11'h000;
         end
         else
         begin
            n.cnt = s.cnt + 11'h001;
         end
      end
   end

   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
      end
      else
      begin
         s <= n;
      end
   end

   assign cnt = s.cnt;
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the address generator.
// Assumes: CPU pins come from the pin model; display pins from here.
// Notes: Outputs sampled at the edge, before its updates land.
`timescale 1ns/1ps
`default_nettype none
`include "vmag_defines.svh"
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, display_n, addr_strobe;
   logic [7:0] s_axi_awaddr, s_axi_araddr, page_mem_data_in, cpu_d;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, char_row_addr_out;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, cpu_tpa, cpu_tpb, cpu_mrd_n, cpu_mwr_n;
   logic cpu_data_lines_oe, char_data_oe, page_mem_select, char_mem_select;
   logic char_mem_write_strobe;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [7:0] cpu_mux_addr_in, cpu_data_lines_out, char_data_out;
   logic [7:0] char_col_addr_out;
   logic [2:0] cpu_io_sel;
   logic [10:0] page_mem_addr_out;
   logic [14:0] bitmap_addr_out;
   wire logic [7:0] cpu_data_lines_in, char_data_in;
   int err_count, num_checks;
   // Shared pins resolve to whoever drives them; memory answers 8'hC3
   assign cpu_data_lines_in = cpu_data_lines_oe ? cpu_data_lines_out : cpu_d;
   assign char_data_in = char_data_oe ? char_data_out : 8'hC3;
   vmag_addr_gen DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_mux_addr_in,
      .cpu_io_sel, .cpu_tpa, .cpu_tpb, .cpu_mrd_n, .cpu_mwr_n, .display_n,
      .addr_strobe, .page_mem_data_in, .cpu_data_lines_in,
      .cpu_data_lines_out, .cpu_data_lines_oe, .char_data_in,
      .char_data_out, .char_data_oe, .page_mem_addr_out,
      .char_row_addr_out, .char_col_addr_out, .page_mem_select,
      .char_mem_select, .char_mem_write_strobe, .bitmap_addr_out);
   vmag_cpu_model cpu (.aclk, .addr(cpu_mux_addr_in), .io_sel(cpu_io_sel),
      .tpa(cpu_tpa), .tpb(cpu_tpb), .mrd_n(cpu_mrd_n), .mwr_n(cpu_mwr_n),
      .data(cpu_d));
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Each channel is released at the edge that takes it
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      for (n = 0; n < 40 && (n == 0 || s_axi_bready); n++)
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b0;
         if (s_axi_bvalid) check("bresp", s_axi_bresp, a > 8'h14 ? 2'h2 : 2'h0);
      end
      if (n >= 40) give_verdict_timeout();
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      for (n = 0; n < 40 && (n == 0 || s_axi_rready); n++)
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b0;
         if (s_axi_rvalid) check("rresp", s_axi_rresp, a > 8'h14 ? 2'h2 : 2'h0);
         if (s_axi_rvalid) d = s_axi_rdata;
      end
      if (n >= 40) give_verdict_timeout();
   endtask
   task automatic give_verdict_timeout();
      err_count++;
      give_verdict();
   endtask
   task automatic char_acc(input logic [15:0] a, input logic wr, input logic [3:0] row, input logic [14:0] bm);
      cpu.mem_start(a, wr, 8'h5A);
      tick(6);
      check("row", char_row_addr_out, row);
      check("col", char_col_addr_out, page_mem_data_in);
      check("csel", {char_mem_select, char_mem_write_strobe}, {1'b1, wr});
      check("bmap", bitmap_addr_out, bm);
      if (wr) check("cdata", {char_data_oe, char_data_out}, 9'h15A);
      else check("cpubus", {cpu_data_lines_oe, cpu_data_lines_out}, 9'h1C3);
      cpu.mem_end();
      tick(6);
   endtask
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs();
      logic [31:0] d;
      axi_rd(`VMAG_CTRL_OFF, d); check("ctrl", d, 32'h0);
      axi_rd(`VMAG_LAST_OFF, d); check("last", d, `VMAG_LAST_RST);
      axi_rd(8'h3C, d); check("unmapped", d, 32'h0);
      axi_wr(8'h3C, 32'hFFFF_FFFF);
      axi_wr(`VMAG_CTRL_OFF, 32'h1);
   endtask
   task automatic t_random();
      cpu.out_io(3'h5, 16'h0523, 8'h01); tick(4);
      check("pma", page_mem_addr_out, 11'h523);
      tick(20); check("pma hold", page_mem_addr_out, 11'h523);
      cpu.mem_start(16'hF9AB, 1'b1, 8'h77); tick(6);
      check("psel", {page_mem_select, page_mem_addr_out}, 12'hD23);
      cpu.mem_end(); tick(6);
      char_acc(16'hF40D, 1'b1, 4'h5, 15'h0);
   endtask
   task automatic t_addressed();
      logic [31:0] d;
      cpu.out_io(3'h6, 16'h07FE, 8'h00); tick(4);
      check("pma", page_mem_addr_out, 11'h7FE);
      cpu.out_io(3'h6, 16'h0100, 8'h00); tick(4);
      check("pma", page_mem_addr_out, 11'h100);
      axi_rd(`VMAG_STAT_OFF, d); check("stat", d[1:0], 2'h3);
      char_acc(16'hF7F2, 1'b0, 4'h2, 15'h0);
      cpu.out_io(3'h5, 16'h0000, 8'h00); tick(4);
      cpu.mem_start(16'hF402, 1'b1, 8'h11); tick(6);
      check("sel off", char_mem_select, 1'b0);
      cpu.mem_end(); tick(6);
   endtask
   task automatic t_pages();
      axi_wr(`VMAG_CTRL_OFF, 32'h0);
      cpu.out_io(3'h5, 16'h0523, 8'h01); tick(4);
      check("page_addr_top_bit", page_mem_addr_out, 11'h123);
      axi_wr(`VMAG_CTRL_OFF, 32'h2); char_acc(16'hF40D, 1'b1, 4'hD, 15'h0);
      axi_wr(`VMAG_CTRL_OFF, 32'h3); char_acc(16'hF40D, 1'b1, 4'h5, 15'h0);
      axi_wr(`VMAG_CTRL_OFF, 32'h5);
      char_acc(16'hF407, 1'b0, 4'h7, {11'h523, 4'h7});
   endtask
   task automatic t_home();
      logic [31:0] d;
      cpu.out_io(3'h7, 16'h0017, 8'h00); tick(4);
      axi_rd(`VMAG_HOME_OFF, d); check("home", d, 32'h14);
      axi_wr(`VMAG_LAST_OFF, 32'h16);
      display_n <= 1'b0; tick(6); display_n <= 1'b1; tick(6);
      axi_rd(`VMAG_RFSH_OFF, d); check("reload", d, 32'h14);
      display_n <= 1'b0; tick(6);
      for (int i = 0; i < 3; i++)
      begin
         addr_strobe <= 1'b1; tick(3); addr_strobe <= 1'b0; tick(4);
         axi_rd(`VMAG_RFSH_OFF, d); check("rfsh", d, i == 2 ? 32'h0 : 32'h15 + i);
      end
      display_n <= 1'b1; tick(6);
   endtask
   initial
   begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, addr_strobe} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
      {display_n, s_axi_wstrb, page_mem_data_in} = {1'b1, 4'hF, 8'h3C};
      {err_count, num_checks} = 64'h0;
      tick(2); aresetn <= 1'b1; tick(4);
      t_regs(); t_random(); t_addressed(); t_pages(); t_home();
      give_verdict();
   end
endmodule
`default_nettype wire

// ---- verification/vmag_checker.sv ----
// Purpose: Port-level assertions for the address generator.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Pin events reach outputs a few cycles late, so windows are 6.
`timescale 1ns/1ps
`default_nettype none
module vmag_checker
(
   input wire logic aclk, // System clock
   input wire logic aresetn, // Reset, active low
   input wire logic display_n, // Display field, active low
   input wire logic cpu_mwr_n, // Memory write, active low
   input wire logic s_axi_bready, // Write response ready
   input wire logic s_axi_rready, // Read data ready
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic [1:0] s_axi_rresp, // Read response
   input wire logic [10:0] page_mem_addr_out, // Page address
   input wire logic [3:0] char_row_addr_out, // Row address
   input wire logic page_mem_select, // Page select
   input wire logic char_mem_select, // Character select
   input wire logic char_mem_write_strobe, // Character write
   input wire logic char_data_oe, // Character data drive
   input wire logic cpu_data_lines_oe, // CPU data drive
   input wire logic [14:0] bitmap_addr_out // Bit-map address
);
   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Write strobe never stands without the select beside it
   a_wr_with_sel: assert property (char_mem_write_strobe |-> char_mem_select)
      else $error("character write without select");
   a_wr_cause: assert property (cpu_mwr_n [*6] |=> !char_mem_write_strobe)
      else $error("character write with no CPU write");
   // Display time belongs to refresh, not to the CPU
   a_disp_quiet: assert property ((!display_n) [*6] |=> !char_mem_select && !page_mem_select)
      else $error("memory select during display");
   a_row_in_disp: assert property ((!display_n) [*6] |=> char_row_addr_out == 4'h0)
      else $error("row address driven during display");
   a_sel_excl: assert property (!(page_mem_select && char_mem_select))
      else $error("page and character selected together");
   a_cdata_dir: assert property (char_data_oe |-> char_mem_select && char_mem_write_strobe)
      else $error("character data driven outside a write");
   a_bus_contend: assert property (!(char_data_oe && cpu_data_lines_oe))
      else $error("both data paths driven");
   a_bmap_form: assert property (bitmap_addr_out == 15'h0 || bitmap_addr_out == {page_mem_addr_out, char_row_addr_out})
      else $error("bit-map address not page and row");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   c_cwrite: cover property (char_mem_write_strobe);
   c_psel: cover property (page_mem_select);
   c_bmap: cover property (bitmap_addr_out != 15'h0);
   c_rerr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind vmag_addr_gen vmag_checker u_chk (.aclk, .aresetn, .display_n,
   .cpu_mwr_n, .s_axi_bready, .s_axi_rready, .s_axi_bvalid, .s_axi_bresp,
   .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .page_mem_addr_out,
   .char_row_addr_out, .page_mem_select, .char_mem_select,
   .char_mem_write_strobe, .char_data_oe, .cpu_data_lines_oe,
   .bitmap_addr_out);
`default_nettype wire

// ---- verification/vmag_cpu_model.sv ----
// Purpose: CPU pin model issuing output instructions and memory cycles.
// Assumes: Strobes held 3 cycles, wider than the 2-cycle minimum.
// Notes: A released data bus shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module vmag_cpu_model
(
   input wire logic aclk, // System clock
   output logic [7:0] addr, // Multiplexed address pins
   output logic [2:0] io_sel, // I/O port number
   output logic tpa, // High-byte strobe
   output logic tpb, // I/O latch strobe
   output logic mrd_n, // Memory read, active low
   output logic mwr_n, // Memory write, active low
   output logic [7:0] data // CPU data drive
);
   // ****************************************************************
   // Bus cycles
   // ****************************************************************
   initial {addr, io_sel, tpa, tpb, mrd_n, mwr_n, data} = {13'h0, 2'h3, 8'hFF};
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // High byte rides on the strobe, low byte follows it
   task automatic put_addr(input logic [15:0] a);
      addr <= a[15:8];
      tpa <= 1'b1;
      tick(3);
      tpa <= 1'b0;
      addr <= a[7:0];
   endtask
   // Leaving access mode is an OUT 5 with bit 0 low
   task automatic out_io(input logic [2:0] p, input logic [15:0] a, input logic [7:0] d);
      @(posedge aclk);
      io_sel <= p;
      put_addr(a);
      data <= d;
      tpb <= 1'b1;
      tick(3);
      tpb <= 1'b0;
      tick(3);
      io_sel <= 3'h0;
      data <= ~d;
   endtask
   task automatic mem_start(input logic [15:0] a, input logic wr, input logic [7:0] d);
      @(posedge aclk);
      put_addr(a);
      data <= wr ? d : ~data;
      mwr_n <= !wr;
      mrd_n <= wr;
   endtask
   task automatic mem_end();
      mwr_n <= 1'b1;
      mrd_n <= 1'b1;
      data <= ~data;
      tick(1);
   endtask
endmodule
`default_nettype wire
